// >>> shared/pfx_pkg.sv
// Constants shared by the pixel special-effects stage.
// Operation
// - Apply the effect chosen by the three-bit mode field to every pixel.
// - Mode 000 forwards luma and both chromas untouched.
// - Mode 001 forces both chromas to zero, luma unchanged.
// - Mode 010 replaces both chromas with the sepia register values.
// - Mode 011 inverts luma and both chromas, giving a negative image.
// - Mode 100 conditionally inverts luma against the threshold in bits 15:8.
// - Mode 101 also inverts both chromas of exactly the pixels whose luma inverted.
// - Sepia Cb is sign at bit 15, magnitude bits 14:8, 0.7 fraction.
// - Sepia Cr is sign at bit 7, magnitude bits 6:0, same format.
// - Sepia register resets to a brownish tint and accepts any programmed pair.
package pfx_pkg;

  localparam int unsigned PFX_ADDR_W = 9;
  localparam int unsigned PFX_DATA_W = 16;
  localparam int unsigned PFX_PIX_W  = 8;
  localparam int unsigned PFX_MODE_W = 3;

  // Register offsets on the internal register port.
  localparam logic [PFX_ADDR_W-1:0] PFX_OFS_MODE  = 9'h1e2;
  localparam logic [PFX_ADDR_W-1:0] PFX_OFS_SEPIA = 9'h1e3;

  // Values after reset.
  localparam logic [PFX_DATA_W-1:0] PFX_RST_MODE  = 16'h7000;
  localparam logic [PFX_DATA_W-1:0] PFX_RST_SEPIA = 16'hb023;

  // Field positions.
  localparam int unsigned PFX_MODE_LSB     = 0;
  localparam int unsigned PFX_THR_LSB      = 8;
  localparam int unsigned PFX_CB_SIGN_BIT  = 15;
  localparam int unsigned PFX_CB_MAG_LSB   = 8;
  localparam int unsigned PFX_CR_SIGN_BIT  = 7;
  localparam int unsigned PFX_CR_MAG_LSB   = 0;
  localparam int unsigned PFX_MAG_W        = 7;

  // Effect codes of the mode field.
  localparam logic [PFX_MODE_W-1:0] PFX_MODE_PASS  = 3'h0;
  localparam logic [PFX_MODE_W-1:0] PFX_MODE_MONO  = 3'h1;
  localparam logic [PFX_MODE_W-1:0] PFX_MODE_SEPIA = 3'h2;
  localparam logic [PFX_MODE_W-1:0] PFX_MODE_NEG   = 3'h3;
  localparam logic [PFX_MODE_W-1:0] PFX_MODE_SOL   = 3'h4;
  localparam logic [PFX_MODE_W-1:0] PFX_MODE_SOL_CHROMA_INV = 3'h5;

  // Chroma edge values for the saturating negation.
  localparam logic [PFX_PIX_W-1:0] PFX_CHROMA_MIN = 8'h80;
  localparam logic [PFX_PIX_W-1:0] PFX_CHROMA_MAX = 8'h7f;
  localparam logic [PFX_PIX_W-1:0] PFX_CHROMA_ZERO = 8'h00;

  // Pipeline latency from an input pixel to its output, in clock cycles.
  localparam int unsigned PFX_LATENCY = 1;

endpackage

// >>> design/pfx_chroma_neg.sv
// Saturating negation of one signed chroma sample.
module pfx_chroma_neg (
  input  wire logic [pfx_pkg::PFX_PIX_W-1:0] chroma_in,
  output wire logic [pfx_pkg::PFX_PIX_W-1:0] chroma_out
);

  // The most negative code has no positive twin, so it clips to the largest positive one.
  assign chroma_out = (chroma_in == pfx_pkg::PFX_CHROMA_MIN) ? pfx_pkg::PFX_CHROMA_MAX
                    : (pfx_pkg::PFX_CHROMA_ZERO - chroma_in);

endmodule

// >>> design/pfx_top.sv
// Per-pixel special-effects stage with its two control registers.
module pfx_top (
  input  wire logic                               clk,
  input  wire logic                               rst_n,
  input  wire logic [pfx_pkg::PFX_ADDR_W-1:0]     reg_addr,
  input  wire logic                               reg_wr_en,
  input  wire logic [pfx_pkg::PFX_DATA_W-1:0]     reg_wdata,
  input  wire logic                               reg_rd_en,
  output logic      [pfx_pkg::PFX_DATA_W-1:0]     reg_rdata,
  output logic                                    reg_rd_valid,
  input  wire logic                               pix_in_valid,
  input  wire logic [pfx_pkg::PFX_PIX_W-1:0]      pix_in_y,
  input  wire logic [pfx_pkg::PFX_PIX_W-1:0]      pix_in_cb,
  input  wire logic [pfx_pkg::PFX_PIX_W-1:0]      pix_in_cr,
  output logic                                    pix_out_valid,
  output logic      [pfx_pkg::PFX_PIX_W-1:0]      pix_out_y,
  output logic      [pfx_pkg::PFX_PIX_W-1:0]      pix_out_cb,
  output logic      [pfx_pkg::PFX_PIX_W-1:0]      pix_out_cr
);

  localparam int unsigned PW = pfx_pkg::PFX_PIX_W;
  localparam int unsigned DW = pfx_pkg::PFX_DATA_W;
  localparam int unsigned MW = pfx_pkg::PFX_MODE_W;
  localparam int unsigned GW = pfx_pkg::PFX_MAG_W;

  logic [MW-1:0] mode_ff;
  logic [PW-1:0] thresh_ff;
  logic [DW-1:0] sepia_ff;
  logic [DW-1:0] nxt_rdata;
  logic [PW-1:0] neg_cb;
  logic [PW-1:0] neg_cr;
  logic [PW-1:0] sepia_cb;
  logic [PW-1:0] sepia_cr;
  logic          luma_over;
  logic [PW-1:0] nxt_y;
  logic [PW-1:0] nxt_cb;
  logic [PW-1:0] nxt_cr;

  // Mode register write: only the mode and threshold fields hold state.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff   <= pfx_pkg::PFX_RST_MODE[pfx_pkg::PFX_MODE_LSB +: MW];
      thresh_ff <= pfx_pkg::PFX_RST_MODE[pfx_pkg::PFX_THR_LSB +: PW];
    end else if (reg_wr_en && (reg_addr == pfx_pkg::PFX_OFS_MODE)) begin
      mode_ff   <= reg_wdata[pfx_pkg::PFX_MODE_LSB +: MW];
      thresh_ff <= reg_wdata[pfx_pkg::PFX_THR_LSB +: PW];
    end
  end

  // Sepia register write: any chroma pair is accepted as the tint.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sepia_ff <= pfx_pkg::PFX_RST_SEPIA;
    end else if (reg_wr_en && (reg_addr == pfx_pkg::PFX_OFS_SEPIA)) begin
      sepia_ff <= reg_wdata;
    end
  end

  // Read decode; reserved bits and unmapped offsets read as zero.
  always_comb begin
    nxt_rdata = '0;
    if (reg_addr == pfx_pkg::PFX_OFS_MODE) begin
      nxt_rdata[pfx_pkg::PFX_MODE_LSB +: MW] = mode_ff;
      nxt_rdata[pfx_pkg::PFX_THR_LSB +: PW]  = thresh_ff;
    end else if (reg_addr == pfx_pkg::PFX_OFS_SEPIA) begin
      nxt_rdata = sepia_ff;
    end
  end

  // Read answers one cycle after the strobe and holds until the next read.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata    <= '0;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata <= nxt_rdata;
      end
    end
  end

  // Sign-magnitude tint turned into signed chroma; a negative zero becomes plain zero.
  always_comb begin
    sepia_cb = {1'b0, sepia_ff[pfx_pkg::PFX_CB_MAG_LSB +: GW]};
    sepia_cr = {1'b0, sepia_ff[pfx_pkg::PFX_CR_MAG_LSB +: GW]};
    if (sepia_ff[pfx_pkg::PFX_CB_SIGN_BIT]) begin
      sepia_cb = pfx_pkg::PFX_CHROMA_ZERO - sepia_cb;
    end
    if (sepia_ff[pfx_pkg::PFX_CR_SIGN_BIT]) begin
      sepia_cr = pfx_pkg::PFX_CHROMA_ZERO - sepia_cr;
    end
  end

  pfx_chroma_neg u_neg_cb (
    .chroma_in  (pix_in_cb),
    .chroma_out (neg_cb)
  );

  pfx_chroma_neg u_neg_cr (
    .chroma_in  (pix_in_cr),
    .chroma_out (neg_cr)
  );

  // A strict comparison keeps pixels equal to the threshold untouched.
  assign luma_over = (pix_in_y > thresh_ff);

  // Effect selection for the pixel now on the input.
  always_comb begin
    nxt_y  = pix_in_y;
    nxt_cb = pix_in_cb;
    nxt_cr = pix_in_cr;
    case (mode_ff)
      pfx_pkg::PFX_MODE_PASS: begin
        nxt_y = pix_in_y;
      end
      pfx_pkg::PFX_MODE_MONO: begin
        nxt_cb = pfx_pkg::PFX_CHROMA_ZERO;
        nxt_cr = pfx_pkg::PFX_CHROMA_ZERO;
      end
      pfx_pkg::PFX_MODE_SEPIA: begin
        nxt_cb = sepia_cb;
        nxt_cr = sepia_cr;
      end
      pfx_pkg::PFX_MODE_NEG: begin
        nxt_y  = ~pix_in_y;
        nxt_cb = neg_cb;
        nxt_cr = neg_cr;
      end
      pfx_pkg::PFX_MODE_SOL: begin
        if (luma_over) begin
          nxt_y = ~pix_in_y;
        end
      end
      pfx_pkg::PFX_MODE_SOL_CHROMA_INV: begin
        if (luma_over) begin
          nxt_y  = ~pix_in_y;
          nxt_cb = neg_cb;
          nxt_cr = neg_cr;
        end
      end
      default: begin
        nxt_y = pix_in_y;
      end
    endcase
  end

  // One register stage; data is only loaded for valid pixels so idle outputs stay quiet.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pix_out_valid <= 1'b0;
    end else begin
      pix_out_valid <= pix_in_valid;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pix_out_y  <= '0;
      pix_out_cb <= '0;
      pix_out_cr <= '0;
    end else if (pix_in_valid) begin
      pix_out_y  <= nxt_y;
      pix_out_cb <= nxt_cb;
      pix_out_cr <= nxt_cr;
    end
  end

  AST_VALID_LATENCY: assert property (
    @(posedge clk) disable iff (!rst_n)
    pix_in_valid |=> pix_out_valid
  ) else $error("Valid pixel did not appear one cycle later.");

  AST_PASS_THROUGH: assert property (
    @(posedge clk) disable iff (!rst_n)
    pix_in_valid && (mode_ff == pfx_pkg::PFX_MODE_PASS)
    |=> (pix_out_y == $past(pix_in_y)) && (pix_out_cb == $past(pix_in_cb))
        && (pix_out_cr == $past(pix_in_cr))
  ) else $error("Pass-through mode altered a pixel.");

  AST_MONO_CHROMA: assert property (
    @(posedge clk) disable iff (!rst_n)
    pix_in_valid && (mode_ff == pfx_pkg::PFX_MODE_MONO)
    |=> (pix_out_cb == 8'h00) && (pix_out_cr == 8'h00) && (pix_out_y == $past(pix_in_y))
  ) else $error("Monochrome mode left chroma or changed luma.");

  AST_SEPIA_CHROMA: assert property (
    @(posedge clk) disable iff (!rst_n)
    pix_in_valid && (mode_ff == pfx_pkg::PFX_MODE_SEPIA)
    |=> (pix_out_cb == ($past(sepia_ff[15]) ? 8'h00 - {1'b0, $past(sepia_ff[14:8])}
                                             : {1'b0, $past(sepia_ff[14:8])}))
        && (pix_out_cr == ($past(sepia_ff[7]) ? 8'h00 - {1'b0, $past(sepia_ff[6:0])}
                                               : {1'b0, $past(sepia_ff[6:0])}))
        && (pix_out_y == $past(pix_in_y))
  ) else $error("Sepia mode chroma does not match the tint register.");

  AST_NEGATIVE: assert property (
    @(posedge clk) disable iff (!rst_n)
    pix_in_valid && (mode_ff == pfx_pkg::PFX_MODE_NEG)
    |=> (pix_out_y == ~$past(pix_in_y))
        && (pix_out_cb == (($past(pix_in_cb) == 8'h80) ? 8'h7f : 8'h00 - $past(pix_in_cb)))
        && (pix_out_cr == (($past(pix_in_cr) == 8'h80) ? 8'h7f : 8'h00 - $past(pix_in_cr)))
  ) else $error("Negative mode did not invert every channel.");

  AST_SOLARIZE_LUMA: assert property (
    @(posedge clk) disable iff (!rst_n)
    pix_in_valid && (mode_ff == pfx_pkg::PFX_MODE_SOL)
    |=> (pix_out_y == (($past(pix_in_y) > $past(thresh_ff)) ? ~$past(pix_in_y)
                                                           : $past(pix_in_y)))
        && (pix_out_cb == $past(pix_in_cb)) && (pix_out_cr == $past(pix_in_cr))
  ) else $error("Solarize mode luma decision is wrong.");

  AST_SOLARIZE_CHROMA: assert property (
    @(posedge clk) disable iff (!rst_n)
    pix_in_valid && (mode_ff == pfx_pkg::PFX_MODE_SOL_CHROMA_INV)
    |=> (($past(pix_in_y) > $past(thresh_ff))
         ? ((pix_out_y == ~$past(pix_in_y))
            && (pix_out_cb == (($past(pix_in_cb) == 8'h80) ? 8'h7f
                                                           : 8'h00 - $past(pix_in_cb)))
            && (pix_out_cr == (($past(pix_in_cr) == 8'h80) ? 8'h7f
                                                           : 8'h00 - $past(pix_in_cr))))
         : ((pix_out_y == $past(pix_in_y)) && (pix_out_cb == $past(pix_in_cb))
            && (pix_out_cr == $past(pix_in_cr))))
  ) else $error("Chroma inversion does not follow luma inversion.");

  AST_AT_THRESHOLD: assert property (
    @(posedge clk) disable iff (!rst_n)
    pix_in_valid && (pix_in_y == thresh_ff)
    && ((mode_ff == pfx_pkg::PFX_MODE_SOL) || (mode_ff == pfx_pkg::PFX_MODE_SOL_CHROMA_INV))
    |=> (pix_out_y == $past(pix_in_y)) && (pix_out_cb == $past(pix_in_cb))
  ) else $error("Pixel at the threshold was inverted.");

  AST_UNUSED_MODE: assert property (
    @(posedge clk) disable iff (!rst_n)
    pix_in_valid && (mode_ff[2:1] == 2'b11)
    |=> (pix_out_y == $past(pix_in_y)) && (pix_out_cb == $past(pix_in_cb))
        && (pix_out_cr == $past(pix_in_cr))
  ) else $error("Unused mode code altered a pixel.");

  AST_SEPIA_WRITE_READ: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_wr_en && (reg_addr == pfx_pkg::PFX_OFS_SEPIA) ##1 !reg_wr_en ##1
    reg_rd_en && (reg_addr == pfx_pkg::PFX_OFS_SEPIA) && !reg_wr_en
    |=> reg_rd_valid && (reg_rdata == $past(reg_wdata, 3))
  ) else $error("Programmed sepia value did not read back.");

  AST_MODE_WRITE: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_wr_en && (reg_addr == pfx_pkg::PFX_OFS_MODE)
    |=> (mode_ff == $past(reg_wdata[2:0])) && (thresh_ff == $past(reg_wdata[15:8]))
  ) else $error("Mode register write was not taken.");

  AST_MODE_HOLD: assert property (
    @(posedge clk) disable iff (!rst_n)
    !(reg_wr_en && (reg_addr == pfx_pkg::PFX_OFS_MODE))
    |=> $stable(thresh_ff) && $stable(mode_ff)
  ) else $error("Mode register changed without a write.");

  AST_VALID_IDLE: assert property (
    @(posedge clk) disable iff (!rst_n)
    !pix_in_valid |=> !pix_out_valid
  ) else $error("Output valid rose without an input pixel.");

  AST_IDLE_HOLD: assert property (
    @(posedge clk) disable iff (!rst_n)
    !pix_in_valid |=> $stable(pix_out_y) && $stable(pix_out_cb) && $stable(pix_out_cr)
  ) else $error("Output pixel changed while no input pixel came.");

  AST_MODE_READ: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd_en && (reg_addr == pfx_pkg::PFX_OFS_MODE)
    |=> reg_rd_valid && (reg_rdata == {$past(thresh_ff), 5'h00, $past(mode_ff)})
  ) else $error("Mode register read returned a wrong word.");

  AST_SEPIA_READ: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd_en && (reg_addr == pfx_pkg::PFX_OFS_SEPIA)
    |=> reg_rd_valid && (reg_rdata == $past(sepia_ff))
  ) else $error("Sepia register read returned a wrong word.");

  AST_UNMAPPED_READ: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_rd_en && (reg_addr != pfx_pkg::PFX_OFS_MODE) && (reg_addr != pfx_pkg::PFX_OFS_SEPIA)
    |=> reg_rd_valid && (reg_rdata == 16'h0000)
  ) else $error("Unmapped offset did not read as zero.");

  AST_READ_PULSE: assert property (
    @(posedge clk) disable iff (!rst_n)
    !reg_rd_en |=> !reg_rd_valid
  ) else $error("Read valid rose without a read strobe.");

  AST_SEPIA_WRITE: assert property (
    @(posedge clk) disable iff (!rst_n)
    reg_wr_en && (reg_addr == pfx_pkg::PFX_OFS_SEPIA) |=> (sepia_ff == $past(reg_wdata))
  ) else $error("Sepia register write was not taken.");

  AST_SEPIA_ZERO_CR: assert property (
    @(posedge clk) disable iff (!rst_n)
    pix_in_valid && (mode_ff == pfx_pkg::PFX_MODE_SEPIA) && (sepia_ff[6:0] == 7'h00)
    |=> (pix_out_cr == 8'h00)
  ) else $error("A zero sepia magnitude gave nonzero chroma.");

  AST_NEG_SATURATE: assert property (
    @(posedge clk) disable iff (!rst_n)
    pix_in_valid && (mode_ff == pfx_pkg::PFX_MODE_NEG) && (pix_in_cb == 8'h80)
    |=> (pix_out_cb == 8'h7f)
  ) else $error("Most negative chroma did not clip on negation.");

  AST_BELOW_THRESHOLD: assert property (
    @(posedge clk) disable iff (!rst_n)
    pix_in_valid && (pix_in_y < thresh_ff)
    && ((mode_ff == pfx_pkg::PFX_MODE_SOL) || (mode_ff == pfx_pkg::PFX_MODE_SOL_CHROMA_INV))
    |=> (pix_out_y == $past(pix_in_y)) && (pix_out_cr == $past(pix_in_cr))
  ) else $error("Pixel below the threshold was inverted.");

endmodule

// >>> sim/pfx_pixel_partner.sv
// Model of the upstream pixel source that feeds the effects stage.
module pfx_pixel_partner (
  input  wire logic                          clk,
  output logic                               pix_in_valid,
  output logic [pfx_pkg::PFX_PIX_W-1:0]      pix_in_y,
  output logic [pfx_pkg::PFX_PIX_W-1:0]      pix_in_cb,
  output logic [pfx_pkg::PFX_PIX_W-1:0]      pix_in_cr
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    pix_in_valid = 1'b0;
    {pix_in_y, pix_in_cb, pix_in_cr} = 24'h000000;
  end

  // Each idle cycle inverts the data left on the bus, so a stage that ignores
  // the qualifier cannot pass by seeing stale data.
  task automatic put(input logic v, input logic [23:0] p);
    @(posedge clk);
    #1;
    pix_in_valid = v;
    if (v) begin
      {pix_in_y, pix_in_cb, pix_in_cr} = p;
    end else begin
      {pix_in_y, pix_in_cb, pix_in_cr} = ~{pix_in_y, pix_in_cb, pix_in_cr};
    end
  endtask
endmodule

// >>> sim/pfx_tb_top.sv
// Self-checking bench for the pixel special-effects stage.
module pfx_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk;
  logic        rst_n;
  logic        reg_wr_en;
  logic        reg_rd_en;
  logic        reg_rd_valid;
  logic        pix_in_valid;
  logic        pix_out_valid;
  logic [8:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [7:0]  pix_in_y, pix_in_cb, pix_in_cr;
  logic [7:0]  pix_out_y, pix_out_cb, pix_out_cr;
  int          num_errors = 0;
  int          n_compared = 0;
  logic [23:0] pix_tbl [5] = '{24'h901080, 24'h70807f, 24'h7100c3, 24'h00ff01, 24'hff7f00};

  pfx_top DUT (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .pix_in_valid(pix_in_valid), .pix_in_y(pix_in_y),
    .pix_in_cb(pix_in_cb), .pix_in_cr(pix_in_cr), .pix_out_valid(pix_out_valid),
    .pix_out_y(pix_out_y), .pix_out_cb(pix_out_cb), .pix_out_cr(pix_out_cr)
  );

  pfx_pixel_partner u_partner (
    .clk(clk), .pix_in_valid(pix_in_valid), .pix_in_y(pix_in_y),
    .pix_in_cb(pix_in_cb), .pix_in_cr(pix_in_cr)
  );

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  function automatic logic [7:0] ng(input logic [7:0] c);
    return (c == 8'h80) ? 8'h7f : -c;
  endfunction

  // Expected pixel from mode, threshold, sepia word and input pixel.
  function automatic logic [23:0] fx(input logic [2:0] m, input logic [7:0] t,
                                     input logic [15:0] s, input logic [23:0] p);
    logic [7:0] y, cb, cr, sb, sr;
    {y, cb, cr} = p;
    sb = s[15] ? -{1'b0, s[14:8]} : {1'b0, s[14:8]};
    sr = s[7] ? -{1'b0, s[6:0]} : {1'b0, s[6:0]};
    case (m)
      3'h1: return {y, 8'h00, 8'h00};
      3'h2: return {y, sb, sr};
      3'h3: return {~y, ng(cb), ng(cr)};
      3'h4: return {(y > t) ? ~y : y, cb, cr};
      3'h5: return (y > t) ? {~y, ng(cb), ng(cr)} : p;
      default: return p;
    endcase
  endfunction

  task automatic chk(input logic [24:0] seen, input logic [24:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    reg_wr_en = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr_en = 1'b0;
  endtask

  task automatic rd(input logic [8:0] a, input logic [15:0] e);
    @(posedge clk);
    #1;
    reg_rd_en = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1;
    reg_rd_en = 1'b0;
    chk({8'h00, reg_rd_valid, reg_rdata}, {9'h001, e});
  endtask

  // Back-to-back pixels, then one idle cycle where the output must hold.
  task automatic run(input logic [2:0] m, input logic [7:0] t, input logic [15:0] s);
    for (int i = 0; i <= 5; i++) begin
      u_partner.put(i < 5, (i < 5) ? pix_tbl[i] : 24'h000000);
      if (i > 0) begin
        chk({pix_out_valid, pix_out_y, pix_out_cb, pix_out_cr},
            {1'b1, fx(m, t, s, pix_tbl[i-1])});
      end
    end
    u_partner.put(1'b0, 24'h000000);
    chk({pix_out_valid, pix_out_y, pix_out_cb, pix_out_cr}, {1'b0, fx(m, t, s, pix_tbl[4])});
  endtask

  task automatic results();
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // The whole sequence needs well under two thousand cycles.
  initial begin
    #20000;
    num_errors++;
    results();
  end

  initial begin
    rst_n = 1'b0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 9'h000;
    reg_wdata = 16'h0000;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rd(pfx_pkg::PFX_OFS_MODE, 16'h7000);
    rd(pfx_pkg::PFX_OFS_SEPIA, 16'hb023);
    run(3'h0, 8'h70, 16'hb023);
    wr(9'h1e4, 16'hffff);
    rd(9'h1e4, 16'h0000);
    rd(pfx_pkg::PFX_OFS_MODE, 16'h7000);
    for (int m = 0; m < 8; m++) begin
      wr(pfx_pkg::PFX_OFS_MODE, {8'h70, 5'h1f, m[2:0]});
      rd(pfx_pkg::PFX_OFS_MODE, {8'h70, 5'h00, m[2:0]});
      run(m[2:0], 8'h70, 16'hb023);
    end
    wr(pfx_pkg::PFX_OFS_SEPIA, 16'h8580);
    rd(pfx_pkg::PFX_OFS_SEPIA, 16'h8580);
    wr(pfx_pkg::PFX_OFS_MODE, 16'hfe05);
    run(3'h5, 8'hfe, 16'h8580);
    wr(pfx_pkg::PFX_OFS_MODE, 16'hfe02);
    run(3'h2, 8'hfe, 16'h8580);
    // A second reset in mid-run must bring both registers back to their reset words.
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    chk({pix_out_valid, pix_out_y, pix_out_cb, pix_out_cr}, 25'h0);
    rst_n = 1'b1;
    rd(pfx_pkg::PFX_OFS_MODE, 16'h7000);
    rd(pfx_pkg::PFX_OFS_SEPIA, 16'hb023);
    run(3'h0, 8'h70, 16'hb023);
    results();
  end
endmodule
